// file: ubcb_comparator.sv
/*
  Channel B break comparator: break address, address mask, break data
  and data mask registers, compared against one of the internal, local,
  x memory or y memory buses, with a registered match output.
  Assumes the bus selection and operand size bits come from the channel B
  bus cycle register on the same clock, and that the monitored buses are
  driven by core logic on ref_clk_i, so none is synchronised.
*/
`include "ubcb_params.svh"
`timescale 1ns/1ps
`default_nettype none

// register map, byte offsets:
//   00 break address
//   04 break address mask
//   08 break data
//   0c break data mask
//   10 status
// status word:
//   bit 0      address hit
//   bit 1      data hit
//   bit 2      channel hit
//   bit 3      sticky hit, 1 clears
//   bits 6:4   bus in use
//   bits 31:16 hit count
// writing 1 to bit 3 also clears
// the count; a hit in that cycle
// wins, so that hit is not lost
// unmapped writes are dropped,
// unmapped reads return zero

module ubcb_comparator
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [31:0]      reg_rdata_o,
  // selection and size bits of the bus cycle register
  input  wire logic        bus_cycle_select_hi_i,
  input  wire logic        bus_cycle_select_lo_i,
  input  wire logic        xy_memory_enable_i,
  input  wire logic        xy_memory_choice_i,
  input  wire logic [1:0]  operand_size_i,
  // internal bus
  input  wire logic [31:0] internal_address_bus_i,
  input  wire logic [31:0] internal_data_bus_i,
  input  wire logic        internal_cycle_i,
  // local bus
  input  wire logic [31:0] local_address_bus_i,
  input  wire logic [31:0] local_data_bus_i,
  input  wire logic        local_cycle_i,
  // x memory bus
  input  wire logic [15:0] x_memory_address_bus_i,
  input  wire logic [15:0] x_memory_data_bus_i,
  input  wire logic        x_memory_cycle_i,
  // y memory bus
  input  wire logic [15:0] y_memory_address_bus_i,
  input  wire logic [15:0] y_memory_data_bus_i,
  input  wire logic        y_memory_cycle_i,
  // results
  output logic             address_match_o,
  output logic             data_match_o,
  output logic             match_o
);

  // software-visible state
  logic [31:0]         break_address_b_r;
  logic [31:0]         break_address_mask_b_r;
  logic [31:0]         break_data_b_r;
  logic [31:0]         break_data_mask_b_r;
  logic                sticky_hit_r;
  logic [15:0]         hit_count_r;
  logic [15:0]         hit_count_nxt;
  logic [31:0]         reg_rdata_r;
  logic [31:0]         status_word;

  // registered comparison results
  logic                address_match_r;
  logic                data_match_r;
  logic                match_r;

  // selector outputs
  ubcb_pkg::ubcb_bus_e sel_bus;
  logic [31:0]         sel_addr;
  logic [31:0]         sel_addr_ignore;
  logic [31:0]         sel_data;
  logic [31:0]         sel_data_ignore;
  logic                sel_cycle;

  // comparator outputs and qualifiers
  logic                addr_equal;
  logic                data_equal;
  logic                data_included;
  logic                hit_now;

  // decoded register accesses
  logic                wr_addr;
  logic                wr_addr_mask;
  logic                wr_data;
  logic                wr_data_mask;
  logic                wr_status;

  // exact decode: an alias would let a stray write move a break word
  // write decode; an unmapped write is dropped without effect
  assign wr_addr      = reg_write_i && (reg_addr_i == `UBCB_OFS_BREAK_ADDRESS_B);
  assign wr_addr_mask = reg_write_i && (reg_addr_i == `UBCB_OFS_BREAK_ADDRESS_MASK_B);
  assign wr_data      = reg_write_i && (reg_addr_i == `UBCB_OFS_BREAK_DATA_B);
  assign wr_data_mask = reg_write_i && (reg_addr_i == `UBCB_OFS_BREAK_DATA_MASK_B);
  assign wr_status    = reg_write_i && (reg_addr_i == `UBCB_OFS_STATUS_B);

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      break_address_b_r <= `UBCB_RST_WORD;
    else if (wr_addr)
      break_address_b_r <= reg_wdata_i;
  end

  // break address mask, zero after reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      break_address_mask_b_r <= `UBCB_RST_WORD;
    else if (wr_addr_mask)
      break_address_mask_b_r <= reg_wdata_i;
  end

  // break data; byte duplication is left to software
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      break_data_b_r <= `UBCB_RST_WORD;
    else if (wr_data)
      break_data_b_r <= reg_wdata_i;
  end

  // break data mask, zero after reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      break_data_mask_b_r <= `UBCB_RST_WORD;
    else if (wr_data_mask)
      break_data_mask_b_r <= reg_wdata_i;
  end

  // bus selection and lane alignment; the x and y buses are 16 bits
  // wide, so the selector places them in the lanes the break words
  // keep for them and marks the rest ignored, letting one pair of
  // comparators serve all four buses
  ubcb_bus_select u_select
  (
    .cycle_select_i         ({bus_cycle_select_hi_i, bus_cycle_select_lo_i}),
    .xy_memory_enable_i     (xy_memory_enable_i),
    .xy_memory_choice_i     (xy_memory_choice_i),
    .internal_address_bus_i (internal_address_bus_i),
    .internal_data_bus_i    (internal_data_bus_i),
    .internal_cycle_i       (internal_cycle_i),
    .local_address_bus_i    (local_address_bus_i),
    .local_data_bus_i       (local_data_bus_i),
    .local_cycle_i          (local_cycle_i),
    .x_memory_address_bus_i (x_memory_address_bus_i),
    .x_memory_data_bus_i    (x_memory_data_bus_i),
    .x_memory_cycle_i       (x_memory_cycle_i),
    .y_memory_address_bus_i (y_memory_address_bus_i),
    .y_memory_data_bus_i    (y_memory_data_bus_i),
    .y_memory_cycle_i       (y_memory_cycle_i),
    .bus_o                  (sel_bus),
    .addr_o                 (sel_addr),
    .addr_ignore_o          (sel_addr_ignore),
    .data_o                 (sel_data),
    .data_ignore_o          (sel_data_ignore),
    .cycle_o                (sel_cycle)
  );

  ubcb_masked_compare u_addr_cmp
  (
    .ref_i    (break_address_b_r),
    .bus_i    (sel_addr),
    .mask_i   (break_address_mask_b_r),
    .ignore_i (sel_addr_ignore),
    .equal_o  (addr_equal)
  );

  ubcb_masked_compare u_data_cmp
  (
    .ref_i    (break_data_b_r),
    .bus_i    (sel_data),
    .mask_i   (break_data_mask_b_r),
    .ignore_i (sel_data_ignore),
    .equal_o  (data_equal)
  );

  // data only counts once an operand size is set
  assign data_included = (operand_size_i != `UBCB_SIZE_NONE);

  // channel hit in a qualifying cycle; with no operand size the
  // data compare still runs but cannot block the hit
  assign hit_now = sel_cycle && addr_equal && (data_equal || !data_included);

  // the flops cost one cycle of latency but keep the long compare
  // chain away from the output pins
  // registered results; address and data flags only in qualifying cycles
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      address_match_r <= 1'b0;
      data_match_r    <= 1'b0;
      match_r         <= 1'b0;
    end
    else
    begin
      address_match_r <= sel_cycle && addr_equal;
      data_match_r    <= sel_cycle && data_included && data_equal;
      match_r         <= hit_now;
    end
  end

  // sticky hit: a hit in the clearing cycle wins over the clear, so a
  // debugger that reads and then clears keeps it, but loses any hit from the read cycle to the cycle before the clear
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      sticky_hit_r <= 1'b0;
    else if (hit_now)
      sticky_hit_r <= 1'b1;
    else if (wr_status && reg_wdata_i[`UBCB_ST_STICKY_BIT])
      sticky_hit_r <= 1'b0;
  end

  // saturating hit count; saturation keeps a long run from reading as few
  always_comb
  begin
    hit_count_nxt = hit_count_r;
    if (wr_status && reg_wdata_i[`UBCB_ST_STICKY_BIT])
      hit_count_nxt = `UBCB_RST_COUNT;
    if (hit_now && (hit_count_nxt != 16'hffff))
      hit_count_nxt = hit_count_nxt + 16'h0001;
  end

  // hit count register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      hit_count_r <= `UBCB_RST_COUNT;
    else
      hit_count_r <= hit_count_nxt;
  end

  // status word: live results, sticky flag, bus in use and hit count
  always_comb
  begin
    status_word                           = `UBCB_RST_WORD;
    status_word[`UBCB_ST_ADDR_HIT_BIT]    = address_match_r;
    status_word[`UBCB_ST_DATA_HIT_BIT]    = data_match_r;
    status_word[`UBCB_ST_MATCH_BIT]       = match_r;
    status_word[`UBCB_ST_STICKY_BIT]      = sticky_hit_r;
    status_word[`UBCB_ST_BUS_LSB +: 3]    = sel_bus;
    status_word[`UBCB_ST_COUNT_LSB +: 16] = hit_count_r;
  end

  // reads have no side effect, so a debugger may poll at will
  // read data stand one cycle after the strobe only; unmapped reads zero
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      reg_rdata_r <= `UBCB_RST_WORD;
    else if (reg_read_i)
    begin
      unique case (reg_addr_i)
        `UBCB_OFS_BREAK_ADDRESS_B:      reg_rdata_r <= break_address_b_r;
        `UBCB_OFS_BREAK_ADDRESS_MASK_B: reg_rdata_r <= break_address_mask_b_r;
        `UBCB_OFS_BREAK_DATA_B:         reg_rdata_r <= break_data_b_r;
        `UBCB_OFS_BREAK_DATA_MASK_B:    reg_rdata_r <= break_data_mask_b_r;
        `UBCB_OFS_STATUS_B:             reg_rdata_r <= status_word;
        default:                        reg_rdata_r <= `UBCB_RST_WORD;
      endcase
    end
    else
      reg_rdata_r <= `UBCB_RST_WORD;
  end

  // outputs straight from flip-flops
  assign reg_rdata_o     = reg_rdata_r;
  assign address_match_o = address_match_r;
  assign data_match_o    = data_match_r;
  assign match_o         = match_r;

endmodule : ubcb_comparator

`default_nettype wire

// file: ubcb_params.svh
/*
  Constants of the channel B break comparator: register offsets,
  reset values, field positions and bus cycle select codes.
  Assumes inclusion by its bare name from every file that needs it.
*/
`ifndef UBCB_PARAMS_SVH
`define UBCB_PARAMS_SVH

// register byte offsets on the plain register port
`define UBCB_OFS_BREAK_ADDRESS_B       8'h00
`define UBCB_OFS_BREAK_ADDRESS_MASK_B  8'h04
`define UBCB_OFS_BREAK_DATA_B          8'h08
`define UBCB_OFS_BREAK_DATA_MASK_B     8'h0c
`define UBCB_OFS_STATUS_B              8'h10

// reset values
`define UBCB_RST_WORD                  32'h0000_0000
`define UBCB_RST_COUNT                 16'h0000

// status register fields
`define UBCB_ST_ADDR_HIT_BIT           0
`define UBCB_ST_DATA_HIT_BIT           1
`define UBCB_ST_MATCH_BIT              2
`define UBCB_ST_STICKY_BIT             3
`define UBCB_ST_BUS_LSB                4
`define UBCB_ST_COUNT_LSB              16

// two-bit bus cycle select codes
`define UBCB_CYC_NONE                  2'h0
`define UBCB_CYC_LOCAL                 2'h1
`define UBCB_CYC_INTERNAL              2'h2
`define UBCB_CYC_LOCAL_ALT             2'h3

// operand size code that leaves data out of the condition
`define UBCB_SIZE_NONE                 2'h0

// x and y memory bus layout inside the 32-bit break words
`define UBCB_XADDR_IGNORE              32'h0001_ffff
`define UBCB_YADDR_IGNORE              32'hffff_0001
`define UBCB_XDATA_IGNORE              32'h0000_ffff
`define UBCB_YDATA_IGNORE              32'hffff_0000

`endif

// file: ubcb_pkg.sv
/*
  Types of the channel B break comparator.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package ubcb_pkg;

  // the monitored bus picked for channel B
  typedef enum logic [2:0]
  {
    bus_none,
    bus_internal,
    bus_local,
    bus_xmem,
    bus_ymem
  } ubcb_bus_e;

endpackage : ubcb_pkg

`default_nettype wire

// file: ubcb_bus_select.sv
/*
  Bus selector: decodes the channel B bus selection bits into one of
  four monitored buses, or none, and lines its address and data up with the
  32-bit break words, with the bits that bus cannot supply ignored.
  Assumes all inputs are on the comparator's clock; purely combinational.
*/
`include "ubcb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ubcb_bus_select
(
  // selection bits
  input  wire logic [1:0]       cycle_select_i,
  input  wire logic             xy_memory_enable_i,
  input  wire logic             xy_memory_choice_i,
  // monitored buses
  input  wire logic [31:0]      internal_address_bus_i,
  input  wire logic [31:0]      internal_data_bus_i,
  input  wire logic             internal_cycle_i,
  input  wire logic [31:0]      local_address_bus_i,
  input  wire logic [31:0]      local_data_bus_i,
  input  wire logic             local_cycle_i,
  input  wire logic [15:0]      x_memory_address_bus_i,
  input  wire logic [15:0]      x_memory_data_bus_i,
  input  wire logic             x_memory_cycle_i,
  input  wire logic [15:0]      y_memory_address_bus_i,
  input  wire logic [15:0]      y_memory_data_bus_i,
  input  wire logic             y_memory_cycle_i,
  // aligned view of the selected bus
  output ubcb_pkg::ubcb_bus_e   bus_o,
  output logic [31:0]           addr_o,
  output logic [31:0]           addr_ignore_o,
  output logic [31:0]           data_o,
  output logic [31:0]           data_ignore_o,
  output logic                  cycle_o
);

  always_comb
  begin
    unique case (cycle_select_i)
      `UBCB_CYC_NONE:     bus_o = ubcb_pkg::bus_none;
      `UBCB_CYC_INTERNAL: bus_o = ubcb_pkg::bus_internal;
      default:
      begin
        if (!xy_memory_enable_i)
          bus_o = ubcb_pkg::bus_local;
        else if (!xy_memory_choice_i)
          bus_o = ubcb_pkg::bus_xmem;
        else
          bus_o = ubcb_pkg::bus_ymem;
      end
    endcase
  end

  // bus routing; x/y lanes placed where the break words hold them
  always_comb
  begin
    addr_o        = `UBCB_RST_WORD;
    addr_ignore_o = `UBCB_RST_WORD;
    data_o        = `UBCB_RST_WORD;
    data_ignore_o = `UBCB_RST_WORD;
    cycle_o       = 1'b0;
    unique case (bus_o)
      ubcb_pkg::bus_none:
        cycle_o = 1'b0;
      ubcb_pkg::bus_internal:
      begin
        addr_o  = internal_address_bus_i;
        data_o  = internal_data_bus_i;
        cycle_o = internal_cycle_i;
      end
      ubcb_pkg::bus_local:
      begin
        addr_o  = local_address_bus_i;
        data_o  = local_data_bus_i;
        cycle_o = local_cycle_i;
      end
      ubcb_pkg::bus_xmem:
      begin
        addr_o        = {x_memory_address_bus_i[15:1], 17'h00000};
        addr_ignore_o = `UBCB_XADDR_IGNORE;
        data_o        = {x_memory_data_bus_i, 16'h0000};
        data_ignore_o = `UBCB_XDATA_IGNORE;
        cycle_o       = x_memory_cycle_i;
      end
      ubcb_pkg::bus_ymem:
      begin
        addr_o        = {16'h0000, y_memory_address_bus_i[15:1], 1'b0};
        addr_ignore_o = `UBCB_YADDR_IGNORE;
        data_o        = {16'h0000, y_memory_data_bus_i};
        data_ignore_o = `UBCB_YDATA_IGNORE;
        cycle_o       = y_memory_cycle_i;
      end
      default:
        cycle_o = 1'b0;
    endcase
  end

endmodule : ubcb_bus_select

`default_nettype wire

// file: ubcb_masked_compare.sv
/*
  Masked 32-bit equality: a bit takes part only when neither its mask
  bit nor its ignore bit is set.
  Assumes combinational use on the comparator's clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ubcb_masked_compare
(
  // operands
  input  wire logic [31:0] ref_i,
  input  wire logic [31:0] bus_i,
  input  wire logic [31:0] mask_i,
  input  wire logic [31:0] ignore_i,
  // result
  output logic             equal_o
);

  logic [31:0] bit_ok;

  // per-bit mask: 0 keeps, 1 excludes
  for (genvar n = 0; n < 32; n++)
  begin : g_bit
    assign bit_ok[n] = mask_i[n] | ignore_i[n] | (ref_i[n] == bus_i[n]);
  end

  // all kept bits must agree
  assign equal_o = &bit_ok;

endmodule : ubcb_masked_compare

`default_nettype wire

// file: ubcb_comparator_checker.sv
/* port checker of the channel b comparator, bound to its top module.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module ubcb_comparator_checker
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  // selection and size
  input wire logic        bus_cycle_select_hi_i,
  input wire logic        bus_cycle_select_lo_i,
  input wire logic        xy_memory_enable_i,
  input wire logic        xy_memory_choice_i,
  input wire logic [1:0]  operand_size_i,
  // qualifying cycles
  input wire logic        internal_cycle_i,
  input wire logic        local_cycle_i,
  input wire logic        x_memory_cycle_i,
  input wire logic        y_memory_cycle_i,
  // results
  input wire logic        address_match_o,
  input wire logic        data_match_o,
  input wire logic        match_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // reset is the trigger here, so it must not disable this one
  reset_clear_a:
    assert property (disable iff (1'b0) rst_i |=> !match_o && !address_match_o && !data_match_o)
      else $error("hit right after reset");
  none_code_a:
    assert property (!bus_cycle_select_hi_i && !bus_cycle_select_lo_i |=> !address_match_o)
      else $error("hit with no bus selected");
  // a hit needs a cycle on the chosen bus, whatever the others do
  internal_cycle_a:
    assert property (bus_cycle_select_hi_i && !bus_cycle_select_lo_i && !internal_cycle_i
      |=> !address_match_o) else $error("internal hit without a cycle");
  local_cycle_a:
    assert property (bus_cycle_select_lo_i && !xy_memory_enable_i && !local_cycle_i
      |=> !address_match_o) else $error("local hit without a cycle");
  x_cycle_a:
    assert property (bus_cycle_select_lo_i && xy_memory_enable_i && !xy_memory_choice_i
      && !x_memory_cycle_i |=> !address_match_o) else $error("x hit without a cycle");
  y_cycle_a:
    assert property (bus_cycle_select_lo_i && xy_memory_enable_i && xy_memory_choice_i
      && !y_memory_cycle_i |=> !address_match_o) else $error("y hit without a cycle");
  match_addr_a:
    assert property (match_o |-> address_match_o) else $error("match without address");
  match_data_a:
    assert property (match_o && $past(operand_size_i) != 2'h0 |-> data_match_o)
      else $error("match without data");
  size_none_a:
    assert property (operand_size_i == 2'h0 |=> !data_match_o) else $error("data hit, no size");
  read_idle_a:
    assert property (!reg_read_i |=> reg_rdata_o == 32'h0) else $error("read data not idle");
  write_read_a:
    assert property (reg_write_i && reg_addr_i == 8'h08 ##1 reg_read_i && reg_addr_i == 8'h08
      |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("write not read back");
endmodule : ubcb_comparator_checker

bind ubcb_comparator ubcb_comparator_checker chk (.*);

`default_nettype wire

// file: ubcb_core_bus_model.sv
/* core bus model: random traffic on the four monitored buses, and on
   request one cycle on a chosen bus; x and y take the upper and lower
   halves of the request words. assumes requests on ref_clk_i. */
`timescale 1ns/1ps
`default_nettype none

module ubcb_core_bus_model
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // request: bus 0 internal, 1 local, 2 x, 3 y
  input wire logic        go_i,
  input wire logic [1:0]  go_bus_i,
  input wire logic [31:0] go_addr_i,
  input wire logic [31:0] go_data_i,
  // monitored buses
  output logic [31:0]     internal_address_bus_o,
  output logic [31:0]     internal_data_bus_o,
  output logic [31:0]     local_address_bus_o,
  output logic [31:0]     local_data_bus_o,
  output logic [15:0]     x_memory_address_bus_o,
  output logic [15:0]     x_memory_data_bus_o,
  output logic [15:0]     y_memory_address_bus_o,
  output logic [15:0]     y_memory_data_bus_o,
  output logic [3:0]      cycles_o
);
  // internal words are random unless requested, local words unless go_bus_i picks local; x and y words always carry the request words
  always_ff @(posedge ref_clk_i)
  begin
    internal_address_bus_o <= $urandom;
    internal_data_bus_o <= $urandom;
    local_address_bus_o <= go_bus_i == 2'h1 ? go_addr_i : $urandom;
    local_data_bus_o <= go_bus_i == 2'h1 ? go_data_i : $urandom;
    x_memory_address_bus_o <= go_addr_i[31:16];
    x_memory_data_bus_o <= go_data_i[31:16];
    y_memory_address_bus_o <= go_addr_i[15:0];
    y_memory_data_bus_o <= go_data_i[15:0];
    cycles_o <= rst_i ? 4'h0 : 4'($urandom) | (go_i ? 4'h1 << go_bus_i : 4'h0);
    if (go_i && go_bus_i == 2'h0)
    begin
      internal_address_bus_o <= go_addr_i;
      internal_data_bus_o <= go_data_i;
    end
  end
endmodule : ubcb_core_bus_model

`default_nettype wire

// file: testbench.sv
/* testbench of the channel b comparator: register traffic and bus cycles
   against a reference of the compare. assumes the core bus model. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // design inputs and outputs
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic bus_cycle_select_hi_i = 1'b0;
  logic bus_cycle_select_lo_i = 1'b0;
  logic xy_memory_enable_i = 1'b0;
  logic xy_memory_choice_i = 1'b0;
  logic [1:0] operand_size_i = 2'h0;
  logic [31:0] internal_address_bus_i, internal_data_bus_i;
  logic [31:0] local_address_bus_i, local_data_bus_i;
  logic [15:0] x_memory_address_bus_i, x_memory_data_bus_i;
  logic [15:0] y_memory_address_bus_i, y_memory_data_bus_i;
  logic internal_cycle_i, local_cycle_i, x_memory_cycle_i, y_memory_cycle_i;
  logic address_match_o, data_match_o, match_o;
  // bench state
  logic go_i = 1'b0;
  logic [1:0] go_bus_i = 2'h0;
  logic [31:0] go_addr_i = 32'h0;
  logic [31:0] go_data_i = 32'h0;
  logic [31:0] regs [4];
  logic [2:0] exp_r = 3'h0;
  logic rd_pend = 1'b0;
  logic [31:0] rd_exp = 32'h0;
  logic [31:0] r_sel = 32'h0;
  logic [15:0] count_x = 16'h0;
  logic [2:0] bus_x = 3'h0;
  logic sticky_x = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  // 200 MHz clock
  always #2.5 ref_clk_i = ~ref_clk_i;

  ubcb_comparator uut (.*);

  ubcb_core_bus_model core
  (
    .ref_clk_i,
    .rst_i,
    .go_i,
    .go_bus_i,
    .go_addr_i,
    .go_data_i,
    .internal_address_bus_o(internal_address_bus_i),
    .internal_data_bus_o   (internal_data_bus_i),
    .local_address_bus_o   (local_address_bus_i),
    .local_data_bus_o      (local_data_bus_i),
    .x_memory_address_bus_o(x_memory_address_bus_i),
    .x_memory_data_bus_o   (x_memory_data_bus_i),
    .y_memory_address_bus_o(y_memory_address_bus_i),
    .y_memory_data_bus_o   (y_memory_data_bus_i),
    .cycles_o              ({y_memory_cycle_i, x_memory_cycle_i, local_cycle_i, internal_cycle_i})
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // expected {match, data, address} for this cycle's buses and break words
  function automatic logic [2:0] exp_hit();
    logic [31:0] a, d, ai, di;
    logic cyc, am, dm, inc;
    a = local_address_bus_i;
    d = local_data_bus_i;
    cyc = local_cycle_i;
    ai = 32'h0;
    di = 32'h0;
    // internal bus in full, local otherwise
    if (bus_cycle_select_hi_i && !bus_cycle_select_lo_i)
    begin
      a = internal_address_bus_i;
      d = internal_data_bus_i;
      cyc = internal_cycle_i;
    end
    // x words in the upper half, y in the lower
    else if (xy_memory_enable_i)
    begin
      a = xy_memory_choice_i ? {16'h0, y_memory_address_bus_i} : {x_memory_address_bus_i, 16'h0};
      d = xy_memory_choice_i ? {16'h0, y_memory_data_bus_i} : {x_memory_data_bus_i, 16'h0};
      cyc = xy_memory_choice_i ? y_memory_cycle_i : x_memory_cycle_i;
      ai = xy_memory_choice_i ? 32'hffff_0001 : 32'h0001_ffff;
      di = xy_memory_choice_i ? 32'hffff_0000 : 32'h0000_ffff;
    end
    cyc = cyc && (bus_cycle_select_hi_i || bus_cycle_select_lo_i);
    inc = operand_size_i != 2'h0;
    am = cyc && (((a ^ regs[0]) & ~(regs[1] | ai)) == 32'h0);
    dm = cyc && inc && (((d ^ regs[2]) & ~(regs[3] | di)) == 32'h0);
    return {am && (dm || !inc), dm, am};
  endfunction : exp_hit

  // compare last edge's expectation, then work out this edge's
  always @(posedge ref_clk_i)
  begin
    if (cycles > 1)
    begin
      check("hits", exp_r, {match_o, data_match_o, address_match_o});
      check("reg_rdata_o", rd_pend ? rd_exp : 32'h0, reg_rdata_o);
    end
    rd_pend = reg_read_i && !rst_i;
    // status: live hits, sticky flag, bus in use, hit count
    bus_x = !bus_cycle_select_lo_i ? {2'h0, bus_cycle_select_hi_i}
      : !xy_memory_enable_i ? 3'h2 : 3'h3 + 3'(xy_memory_choice_i);
    rd_exp = reg_addr_i < 8'h10 ? regs[reg_addr_i[3:2]]
      : reg_addr_i == 8'h10 ? {count_x, 9'h0, bus_x, sticky_x, exp_r} : 32'h0;
    exp_r = rst_i ? 3'h0 : exp_hit();
    // a hit beats a clear in the same cycle
    if (rst_i || reg_write_i && reg_addr_i == 8'h10 && reg_wdata_i[3])
      {count_x, sticky_x} = 17'h0;
    if (exp_r[2])
      {count_x, sticky_x} = {count_x + 16'h1, 1'b1};
    if (rst_i)
      regs = '{default: 32'h0};
    else if (reg_write_i && reg_addr_i < 8'h10)
      regs[reg_addr_i[3:2]] = reg_wdata_i;
  end

  // a hang counts as a mismatch
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 25000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // one register strobe, or none, per cycle
  task automatic bus_op(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_write_i <= op == 2'h1;
    reg_read_i <= op == 2'h2;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask : bus_op

  // random cycle; requests are often steered onto the selected bus
  task automatic rand_cycle(input logic ops);
    logic [31:0] r, d;
    logic [2:0] k;
    r = $urandom;
    d = $urandom;
    k = r[4:2] % 3'h5;
    if (k[2] && r[27])
      k = 3'h5;
    if (k[0])
      d = d & $urandom & $urandom;
    // byte lanes kept equal for byte-size breaks
    if (k[1])
      d[15:8] = d[7:0];
    // word-move style break: data compared in the upper half only
    if (r[28] && k == 3'h3)
      d[15:0] = 16'hffff;
    bus_op(ops && r[1:0] != 2'h3 ? r[1:0] : 2'h0, {3'h0, k, 2'h0}, d);
    // selection trails the request a cycle, as the bus model registers it
    {bus_cycle_select_hi_i, bus_cycle_select_lo_i} <= r_sel[15:14];
    xy_memory_enable_i <= r_sel[16];
    xy_memory_choice_i <= r_sel[17];
    r_sel = r;
    // size given whenever data takes part
    operand_size_i <= r[20:19];
    go_i <= r[5];
    go_bus_i <= !r[18] ? r[7:6] : r[15:14] == 2'h2 ? 2'h0 : r[16] ? {1'b1, r[17]} : 2'h1;
    go_addr_i <= regs[0] ^ (r[8] ? 32'h1 << r[13:9] : 32'h0);
    go_data_i <= regs[2] ^ (r[21] ? 32'h1 << r[26:22] : 32'h0);
  endtask : rand_cycle

  initial
  begin
    void'($urandom(32'h7e716cfd));
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped read
    for (int i = 0; i < 4; i++)
      bus_op(2'h2, 8'(4 * i), 32'h0);
    bus_op(2'h2, 8'h14, 32'h0);
    // write read straight back; unmapped write ignored
    bus_op(2'h1, 8'h08, 32'h5a5a_a5a5);
    bus_op(2'h2, 8'h08, 32'h0);
    bus_op(2'h1, 8'h14, 32'hffff_ffff);
    bus_op(2'h2, 8'h14, 32'h0);
    // everything masked: each qualifying cycle hits
    bus_op(2'h1, 8'h04, 32'hffff_ffff);
    bus_op(2'h1, 8'h0c, 32'hffff_ffff);
    repeat (60) rand_cycle(1'b0);
    bus_op(2'h1, 8'h04, 32'h0);
    bus_op(2'h1, 8'h0c, 32'h0);
    repeat (20000) rand_cycle(1'b1);
    bus_op(2'h0, 8'h00, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
